/* rtl/grcm_regs.sv */
// Gauge readout command map: read-only words, adaptive currents, data log FIFO
`timescale 1ns/1ps
`include "grcm_params.svh"
// Function
// - 0x0e/0x0f reads uncompensated full capacity, refreshed by engine
// - 0x10/0x11 reads compensated remaining capacity
// - 0x12/0x13 reads compensated full charge capacity
// - 0x14/0x15 reads signed one second mean current
// - 0x16/0x17 minutes to empty, 65535 when not discharging
// - 0x18/0x19 minutes to full, 65535 when not charging
// - Idle current starts at initial value, updates on qualifying inner samples
// - Idle update blends about 94 percent old with 6 percent new
// - 0x1c/0x1d idle minutes from uncompensated remaining, 65535 idle
// - Peak load rises to larger loads, halves toward initial after deep cycle
// - 0x20/0x21 peak load minutes, 65535 when not discharging
// - 0x22/0x23 reads remaining energy in mWh
// - 0x24/0x25 signed mean power, zero when idle
// - 0x26/0x27 constant power minutes from engine, 65535 at zero power
// - 0x28 health percent limited to 0x64
// - 0x29 health status code, reserved codes read as not valid
// - Cycle count per profile, bumps at threshold, selected profile's count cleared on new pack
// - 0x2c/0x2d charge percent limited to 100
// - 0x30/0x31 instantaneous current refreshed by engine
// - Log count follows pushes and pops, saturates at 30, drops extras
// - Reading 0x34 pops oldest sample, 0x7fff when empty
// - 0x36/0x37 reads internal die temperature
// - Log-on sets flag, empties FIFO, starts recording
// - Log-off clears flag, stops recording, keeps samples
module grcm_regs import grcm_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `GRCM_SEC_CYCLES
) (
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      ce,
  input  wire grcm_eng_s eng,
  input  wire logic      eng_valid,
  input  wire grcm_cfg_s cfg,
  input  wire logic      profile_sel,
  input  wire logic      new_pack,
  input  wire logic      log_on_subcommand,
  input  wire logic      log_off_subcommand,
  input  wire logic      rd_en,
  input  wire logic [6:0] rd_cmd,
  output logic [7:0]     rd_data,
  output logic           rd_ack,
  output logic           logging_active_flag,
  output logic           sec_tick
);
  localparam int DEPTH = `GRCM_LOG_DEPTH;
  localparam logic [15:0] EMPTY_WORD = `GRCM_LOG_EMPTY;

  grcm_eng_s   snap;
  logic [31:0] sec_cnt;
  logic        init_done;
  logic [15:0] idle_current;
  logic [15:0] idle_sample;
  logic [1:0]  qual_hist;
  logic [15:0] idle_minutes_left;
  logic [15:0] peak_load;
  logic        deep_seen;
  logic        full_prev;
  logic [15:0] cycles [2];
  logic [31:0] dsg_acc;
  logic [15:0] log_mem [DEPTH];
  logic [4:0]  wr_ptr;
  logic [4:0]  rd_ptr;
  logic [4:0]  log_fill_count;
  logic [15:0] pop_hold;
  logic [15:0] word;
  logic        pop;
  logic        push;
  logic        qual_now;
  logic signed [15:0] mean_s;
  logic [15:0] mean_mag;
  logic [15:0] idle_mag;
  logic [19:0] next_idle;
  logic [31:0] thr_mas;
  logic [15:0] health_word;
  logic [7:0]  soh_pct;
  logic [7:0]  soh_code;
  logic [7:0]  soc_pct;
  logic [15:0] mean_power;

  assign mean_s = signed'(snap.mean_current);
  assign mean_mag = mean_s[15] ? 16'(-mean_s) : snap.mean_current;
  assign idle_mag = idle_current[15] ? 16'(-idle_current) : idle_current;
  assign qual_now = (mean_mag > cfg.deadband) &&
                    ({1'b0, mean_mag} <= {cfg.initial_idle, 1'b0});
  assign thr_mas = 32'(cfg.cycle_discharge_threshold * `GRCM_MAS_PER_MAH);
  assign push = sec_tick && logging_active_flag;
  assign pop = rd_en && (rd_cmd == `GRCM_OFF_LOG_POP) && (log_fill_count != 5'h00);

  // One second time base
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sec_cnt <= 32'h0;
      sec_tick <= 1'b0;
    end else if (ce) begin
      sec_tick <= (sec_cnt == SEC_CYCLES - 1);
      sec_cnt <= (sec_cnt == SEC_CYCLES - 1) ? 32'h0 : sec_cnt + 32'h1;
    end
  end

  // Engine snapshot of the estimated values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snap <= '0;
    end else if (ce && eng_valid) begin
      snap <= eng;
    end
  end

  // Idle current adaptation
  always_comb begin
    next_idle = 20'({{4{idle_current[15]}}, idle_current} * 20'd15
                + {{4{idle_sample[15]}}, idle_sample});
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_done <= 1'b0;
      idle_current <= 16'h0;
      idle_sample <= 16'h0;
      qual_hist <= 2'b00;
    end else if (ce) begin
      if (!init_done) begin
        init_done <= 1'b1;
        idle_current <= cfg.initial_idle;
      end else if (sec_tick) begin
        qual_hist <= {qual_hist[0], qual_now};
        idle_sample <= snap.mean_current;
        if (qual_now && (&qual_hist)) begin
          idle_current <= 16'(signed'(next_idle) >>> `GRCM_BLEND_SHIFT);
        end
      end
    end
  end

  // Idle minutes from uncompensated remaining capacity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_minutes_left <= `GRCM_NO_TIME;
    end else if (ce && sec_tick) begin
      if (!snap.discharging || idle_mag == 16'h0) begin
        idle_minutes_left <= `GRCM_NO_TIME;
      end else begin
        idle_minutes_left <= 16'((32'(snap.uncomp_remaining) * `GRCM_MIN_PER_HOUR)
                                 / 32'(idle_mag));
      end
    end
  end

  // Peak load tracking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peak_load <= 16'h0;
      deep_seen <= 1'b0;
      full_prev <= 1'b0;
    end else if (ce) begin
      full_prev <= snap.full_charged;
      if (!init_done) begin
        peak_load <= cfg.initial_peak;
      end else if (snap.full_charged && !full_prev && deep_seen) begin
        peak_load <= 16'(({peak_load[15], peak_load}
                     + {cfg.initial_peak[15], cfg.initial_peak}) >> 1);
        deep_seen <= 1'b0;
      end else begin
        if (mean_s < signed'(peak_load)) begin
          peak_load <= snap.mean_current;
        end
        if (snap.discharging && snap.soc_raw < `GRCM_LOW_SOC) begin
          deep_seen <= 1'b1;
        end
      end
    end
  end

  // Cycle counters, one per cell profile
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cycles[0] <= 16'h0;
      cycles[1] <= 16'h0;
      dsg_acc <= 32'h0;
    end else if (ce) begin
      if (new_pack) begin
        cycles[profile_sel] <= 16'h0;
        dsg_acc <= 32'h0;
      end else if (sec_tick && mean_s[15]) begin
        if (dsg_acc + 32'(mean_mag) >= thr_mas) begin
          dsg_acc <= 32'h0;
          if (cycles[profile_sel] != 16'hffff) begin
            cycles[profile_sel] <= cycles[profile_sel] + 16'h1;
          end
        end else begin
          dsg_acc <= dsg_acc + 32'(mean_mag);
        end
      end
    end
  end

  // Logging flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      logging_active_flag <= 1'b0;
    end else if (ce) begin
      if (log_on_subcommand) begin
        logging_active_flag <= 1'b1;
      end else if (log_off_subcommand) begin
        logging_active_flag <= 1'b0;
      end
    end
  end

  // Log FIFO storage
  always_ff @(posedge clk) begin
    if (ce && push && !log_on_subcommand && log_fill_count != DEPTH[4:0]) begin
      log_mem[wr_ptr] <= snap.mean_current;
    end
  end

  // Log FIFO pointers and count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
      log_fill_count <= 5'h00;
    end else if (ce) begin
      if (log_on_subcommand) begin
        wr_ptr <= 5'h00;
        rd_ptr <= 5'h00;
        log_fill_count <= 5'h00;
      end else begin
        if (push && log_fill_count != DEPTH[4:0]) begin
          wr_ptr <= (wr_ptr == DEPTH[4:0] - 5'h1) ? 5'h00 : wr_ptr + 5'h1;
        end
        if (pop) begin
          rd_ptr <= (rd_ptr == DEPTH[4:0] - 5'h1) ? 5'h00 : rd_ptr + 5'h1;
        end
        if (push && log_fill_count != DEPTH[4:0] && !pop) begin
          log_fill_count <= log_fill_count + 5'h1;
        end else if (pop && !(push && log_fill_count != DEPTH[4:0])) begin
          log_fill_count <= log_fill_count - 5'h1;
        end
      end
    end
  end

  // Word shown at a command pair
  always_comb begin
    soh_pct = (snap.health_percent > `GRCM_PCT_MAX) ? `GRCM_PCT_MAX
              : snap.health_percent;
    soh_code = (snap.health_status > `GRCM_SOH_MAX) ? 8'h00
               : snap.health_status;
    soc_pct = (snap.soc_raw > `GRCM_PCT_MAX) ? `GRCM_PCT_MAX : snap.soc_raw;
    health_word = {soh_code, soh_pct};
    mean_power = (snap.discharging || snap.charging) ? snap.power_raw : 16'h0;
    case ({rd_cmd[6:1], 1'b0})
      `GRCM_OFF_UNCOMP_FULL: word = snap.uncomp_full_capacity;
      `GRCM_OFF_COMP_REM:    word = snap.comp_remaining;
      `GRCM_OFF_COMP_FULL:   word = snap.comp_full;
      `GRCM_OFF_MEAN_CUR:    word = snap.mean_current;
      `GRCM_OFF_TTE:     word = snap.discharging ? snap.tte_raw : `GRCM_NO_TIME;
      `GRCM_OFF_TTF:     word = snap.charging ? snap.ttf_raw : `GRCM_NO_TIME;
      `GRCM_OFF_IDLE_CUR:    word = idle_current;
      `GRCM_OFF_IDLE_TTE:    word = idle_minutes_left;
      `GRCM_OFF_PEAK:        word = peak_load;
      `GRCM_OFF_PEAK_TTE: word = snap.discharging ? snap.peak_tte_raw
                                 : `GRCM_NO_TIME;
      `GRCM_OFF_ENERGY:      word = snap.energy_left;
      `GRCM_OFF_POWER:       word = mean_power;
      `GRCM_OFF_CP_TTE: word = (mean_power == 16'h0) ? `GRCM_NO_TIME
                               : snap.cp_tte_raw;
      `GRCM_OFF_HEALTH:      word = health_word;
      `GRCM_OFF_CYCLES:      word = cycles[profile_sel];
      `GRCM_OFF_SOC:         word = {8'h00, soc_pct};
      `GRCM_OFF_IMPED:       word = snap.impedance;
      `GRCM_OFF_INST_CUR:    word = snap.instant_current;
      `GRCM_OFF_LOG_CNT:     word = {11'h000, log_fill_count};
      `GRCM_OFF_LOG_POP:     word = pop_hold;
      `GRCM_OFF_DIE_TEMP:    word = snap.die_temp;
      `GRCM_OFF_CONFIG:      word = cfg.config_mirror;
      default:               word = 16'h0000;
    endcase
  end

  // Host byte read port; low byte of the buffer pair pops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      rd_ack <= 1'b0;
      pop_hold <= `GRCM_LOG_EMPTY;
    end else if (ce) begin
      rd_ack <= rd_en;
      if (rd_en && rd_cmd == `GRCM_OFF_LOG_POP) begin
        pop_hold <= pop ? log_mem[rd_ptr] : `GRCM_LOG_EMPTY;
        rd_data <= pop ? log_mem[rd_ptr][7:0] : EMPTY_WORD[7:0];
      end else if (rd_en) begin
        rd_data <= rd_cmd[0] ? word[15:8] : word[7:0];
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_pop_req;
    ce && rd_en && rd_cmd == `GRCM_OFF_LOG_POP;
  endsequence
  sequence s_empty_pop;
    s_pop_req ##0 log_fill_count == 5'h00;
  endsequence
  sequence s_push_ok;
    ce && push && !log_on_subcommand && !pop;
  endsequence

  a_tte_idle: assert property (ce && rd_en && rd_cmd == `GRCM_OFF_TTE
    && !snap.discharging |=> rd_data == 8'hff) else $error("tte not 65535");
  a_ttf_idle: assert property (ce && rd_en && rd_cmd == `GRCM_OFF_TTF + 7'h1
    && !snap.charging |=> rd_data == 8'hff) else $error("ttf not 65535");
  a_empty_pop_val: assert property (s_empty_pop |=> rd_data == 8'hff
    && pop_hold == `GRCM_LOG_EMPTY) else $error("empty pop wrong");
  a_count_sat: assert property (log_fill_count <= DEPTH[4:0])
    else $error("log count over depth");
  a_count_pop: assert property (s_pop_req ##0 log_fill_count != 5'h00
    && !push && !log_on_subcommand |=> log_fill_count == $past(log_fill_count) - 5'h1)
    else $error("pop did not decrement");
  a_log_on_clear: assert property (ce && log_on_subcommand |=> log_fill_count == 5'h00
    && logging_active_flag) else $error("log on did not clear");
  a_log_off_keep: assert property (ce && log_off_subcommand && !log_on_subcommand
    && !pop && !push |=> !logging_active_flag && log_fill_count == $past(log_fill_count))
    else $error("log off lost samples");
  a_soc_limit: assert property (soc_pct <= `GRCM_PCT_MAX && soh_pct <= `GRCM_PCT_MAX
    && soh_code <= `GRCM_SOH_MAX) else $error("percent over limit");
  a_cp_zero: assert property (ce && rd_en && rd_cmd == `GRCM_OFF_CP_TTE
    && mean_power == 16'h0 |=> rd_data == 8'hff) else $error("cp tte not 65535");
  a_idle_hold: assert property (ce && init_done && !sec_tick |=> $stable(idle_current))
    else $error("idle current moved off tick");
  a_peak_rise: assert property (ce && init_done && !(snap.full_charged && !full_prev)
    && mean_s < signed'(peak_load) |=> peak_load == $past(snap.mean_current))
    else $error("peak did not follow load");

  // Read port and time base
  a_ack_follow: assert property (ce |=> rd_ack == $past(rd_en))
    else $error("ack not one cycle after read");
  a_sec_pulse: assert property (ce && sec_tick |=> !sec_tick)
    else $error("second pulse too long");
  a_tte_pass: assert property (ce && rd_en && rd_cmd == `GRCM_OFF_TTE && snap.discharging
    |=> rd_data == $past(snap.tte_raw[7:0])) else $error("tte not passed");
  a_health_code: assert property (ce && rd_en && rd_cmd == `GRCM_OFF_HEALTH + 7'h1
    && snap.health_status > `GRCM_SOH_MAX |=> rd_data == 8'h00)
    else $error("reserved health code shown");

  // Log FIFO
  a_push_count: assert property (s_push_ok ##0 log_fill_count != DEPTH[4:0]
    |=> log_fill_count == $past(log_fill_count) + 5'h1)
    else $error("push did not increment");
  a_full_drop: assert property (s_push_ok ##0 log_fill_count == DEPTH[4:0]
    |=> log_fill_count == DEPTH[4:0])
    else $error("full log count moved");
  a_pop_advance: assert property (s_pop_req ##0 log_fill_count != 5'h00
    && !log_on_subcommand |=> rd_ptr != $past(rd_ptr))
    else $error("pop did not advance");

  // Adaptive words and counters
  a_idle_init: assert property ($rose(init_done) |-> idle_current == cfg.initial_idle
    && peak_load == cfg.initial_peak)
    else $error("initial values not loaded");
  a_cycle_clear: assert property (ce && new_pack && !profile_sel
    |=> cycles[0] == 16'h0)
    else $error("new pack did not clear cycles");
endmodule

/* shared/grcm_params.svh */
// Command offsets, field values and timing counts of the gauge readout map
`ifndef GRCM_PARAMS_SVH
`define GRCM_PARAMS_SVH
`define GRCM_OFF_UNCOMP_FULL   7'h0e
`define GRCM_OFF_COMP_REM      7'h10
`define GRCM_OFF_COMP_FULL     7'h12
`define GRCM_OFF_MEAN_CUR      7'h14
`define GRCM_OFF_TTE           7'h16
`define GRCM_OFF_TTF           7'h18
`define GRCM_OFF_IDLE_CUR      7'h1a
`define GRCM_OFF_IDLE_TTE      7'h1c
`define GRCM_OFF_PEAK          7'h1e
`define GRCM_OFF_PEAK_TTE      7'h20
`define GRCM_OFF_ENERGY        7'h22
`define GRCM_OFF_POWER         7'h24
`define GRCM_OFF_CP_TTE        7'h26
`define GRCM_OFF_HEALTH        7'h28
`define GRCM_OFF_CYCLES        7'h2a
`define GRCM_OFF_SOC           7'h2c
`define GRCM_OFF_IMPED         7'h2e
`define GRCM_OFF_INST_CUR      7'h30
`define GRCM_OFF_LOG_CNT       7'h32
`define GRCM_OFF_LOG_POP       7'h34
`define GRCM_OFF_DIE_TEMP      7'h36
`define GRCM_OFF_CONFIG        7'h3a
`define GRCM_NO_TIME           16'hffff
`define GRCM_LOG_EMPTY         16'h7fff
`define GRCM_LOG_DEPTH         30
`define GRCM_PCT_MAX           8'h64
`define GRCM_SOH_MAX           8'h03
`define GRCM_LOW_SOC           8'h32
`define GRCM_BLEND_SHIFT       4
`define GRCM_MAS_PER_MAH       3600
`define GRCM_MIN_PER_HOUR      60
`define GRCM_CLK_HZ            125000000
`define GRCM_SEC_S             1
`define GRCM_SEC_CYCLES        (`GRCM_SEC_S * `GRCM_CLK_HZ)
`endif

/* shared/grcm_pkg.sv */
// Types shared by the gauge readout map
package grcm_pkg;
  typedef struct packed {
    logic [15:0] uncomp_full_capacity;
    logic [15:0] comp_remaining;
    logic [15:0] comp_full;
    logic [15:0] uncomp_remaining;
    logic [15:0] mean_current;
    logic [15:0] instant_current;
    logic [15:0] tte_raw;
    logic [15:0] ttf_raw;
    logic [15:0] peak_tte_raw;
    logic [15:0] energy_left;
    logic [15:0] power_raw;
    logic [15:0] cp_tte_raw;
    logic [7:0]  health_percent;
    logic [7:0]  health_status;
    logic [7:0]  soc_raw;
    logic [15:0] impedance;
    logic [15:0] die_temp;
    logic        discharging;
    logic        charging;
    logic        full_charged;
  } grcm_eng_s;
  typedef struct packed {
    logic [15:0] initial_idle;
    logic [15:0] deadband;
    logic [15:0] initial_peak;
    logic [15:0] cycle_discharge_threshold;
    logic [15:0] config_mirror;
  } grcm_cfg_s;
endpackage

/* tb/grcm_host_model.sv */
// Host model that reads one command word as two byte reads, low byte first
`timescale 1ns/1ps
module grcm_host_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [6:0]  cmd,
  input  wire logic        rd_ack,
  input  wire logic [7:0]  rd_data,
  output logic             rd_en,
  output logic [6:0]       rd_cmd,
  output logic [15:0]      word,
  output logic             done
);
  logic [7:0] lo;
  logic [7:0] hi;

  initial begin
    rd_en = 1'b0;
    rd_cmd = 7'h7f;
    word = 16'h0000;
    done = 1'b0;
  end

  // One request pulse, then the byte is taken at the edge that sees the answer
  task automatic one_byte(input logic [6:0] c, output logic [7:0] b);
    int k;
    rd_cmd <= c;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_cmd <= ~c;
    b = 8'hxx;
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      if (rd_ack === 1'b1) begin
        b = rd_data;
        break;
      end
    end
  endtask

  // Even command first, odd command second, so a pop is paired with its high byte
  always begin
    @(posedge clk);
    done <= 1'b0;
    if (go === 1'b1) begin
      one_byte(cmd, lo);
      one_byte(cmd | 7'h01, hi);
      word <= {hi, lo};
      done <= 1'b1;
    end
  end
endmodule

/* tb/test_gauge_readout_command_map.sv */
// Self-checking testbench of the gauge readout command map
`timescale 1ns/1ps
module test_gauge_readout_command_map import grcm_pkg::*; ;
  logic        clk;
  logic        sys_rst;
  logic        ce;
  grcm_eng_s   eng;
  logic        eng_valid;
  grcm_cfg_s   cfg;
  logic        profile_sel;
  logic        new_pack;
  logic        log_on;
  logic        log_off;
  logic        rd_en;
  logic [6:0]  rd_cmd;
  logic [7:0]  rd_data;
  logic        rd_ack;
  logic        flag;
  logic        sec_tick;
  logic        go;
  logic [6:0]  cmd;
  logic [15:0] word;
  logic        done;
  int          err_count;
  int          n_compared;
  int          cyc;

  grcm_regs #(.SEC_CYCLES(20)) dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .eng(eng), .eng_valid(eng_valid),
    .cfg(cfg), .profile_sel(profile_sel), .new_pack(new_pack),
    .log_on_subcommand(log_on), .log_off_subcommand(log_off), .rd_en(rd_en),
    .rd_cmd(rd_cmd), .rd_data(rd_data), .rd_ack(rd_ack),
    .logging_active_flag(flag), .sec_tick(sec_tick)
  );

  grcm_host_model host (
    .clk(clk), .go(go), .cmd(cmd), .rd_ack(rd_ack), .rd_data(rd_data),
    .rd_en(rd_en), .rd_cmd(rd_cmd), .word(word), .done(done)
  );

  always #4 clk = ~clk;

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [6:0] c, input logic [15:0] exp);
    int i;
    logic [15:0] w;
    go <= 1'b1;
    cmd <= c;
    @(posedge clk);
    go <= 1'b0;
    w = 16'hxxxx;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (done === 1'b1) begin
        w = word;
        break;
      end
    end
    check(w, exp);
  endtask

  // Returns at the edge that sees the n-th second pulse
  task automatic tick(input int n);
    int i;
    int j;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      for (j = 0; j < 40 && sec_tick !== 1'b1; j++) @(posedge clk);
    end
  endtask

  task automatic t_reset_vals();
    rchk(7'h1a, 16'd100);
    rchk(7'h1e, 16'hfc18);
    rchk(7'h34, 16'h7fff);
    rchk(7'h3a, 16'h5a3c);
    rchk(7'h3c, 16'h0000);
  endtask

  task automatic t_words();
    eng <= '{uncomp_full_capacity: 16'h0a11, comp_remaining: 16'h0b22,
             comp_full: 16'h0c33, uncomp_remaining: 16'd100, mean_current: 16'h0123,
             instant_current: 16'hfe01, tte_raw: 16'h0456, ttf_raw: 16'h0567,
             peak_tte_raw: 16'h0678, energy_left: 16'h0789, power_raw: 16'hf89a,
             cp_tte_raw: 16'h09ab, health_percent: 8'h5a, health_status: 8'h02,
             soc_raw: 8'h37, die_temp: 16'h0b9e, discharging: 1'b1, default: '0};
    tick(2);
    rchk(7'h0e, 16'h0a11);
    rchk(7'h10, 16'h0b22);
    rchk(7'h12, 16'h0c33);
    rchk(7'h14, 16'h0123);
    rchk(7'h16, 16'h0456);
    rchk(7'h18, 16'hffff);
    rchk(7'h1c, 16'h003c);
    rchk(7'h20, 16'h0678);
    rchk(7'h22, 16'h0789);
    rchk(7'h24, 16'hf89a);
    rchk(7'h26, 16'h09ab);
    rchk(7'h28, 16'h025a);
    rchk(7'h2c, 16'h0037);
    rchk(7'h30, 16'hfe01);
    rchk(7'h36, 16'h0b9e);
  endtask

  task automatic t_flags();
    int i;
    eng.discharging <= 1'b0;
    eng.charging <= 1'b1;
    eng.health_status <= 8'h07;
    eng.health_percent <= 8'h70;
    eng.soc_raw <= 8'h96;
    tick(2);
    rchk(7'h16, 16'hffff);
    rchk(7'h18, 16'h0567);
    rchk(7'h1c, 16'hffff);
    rchk(7'h20, 16'hffff);
    rchk(7'h24, 16'hf89a);
    rchk(7'h28, 16'h0064);
    rchk(7'h2c, 16'h0064);
    for (i = 0; i < 4; i++) begin
      eng.health_status <= i[7:0];
      rchk(7'h28, {i[7:0], 8'h64});
    end
    eng.charging <= 1'b0;
    tick(1);
    rchk(7'h24, 16'h0000);
    rchk(7'h26, 16'hffff);
  endtask

  task automatic t_log();
    log_on <= 1'b1;
    @(posedge clk);
    log_on <= 1'b0;
    tick(32);
    rchk(7'h32, 16'd30);
    tick(1);
    log_on <= 1'b1;
    eng.mean_current <= 16'hff38;
    @(posedge clk);
    log_on <= 1'b0;
    rchk(7'h32, 16'd0);
    check({15'h0, flag}, 16'h0001);
    tick(1);
    eng.mean_current <= 16'h0064;
    tick(1);
    eng.mean_current <= 16'hfe00;
    tick(1);
    log_off <= 1'b1;
    eng.mean_current <= 16'h0000;
    @(posedge clk);
    log_off <= 1'b0;
    tick(1);
    check({15'h0, flag}, 16'h0000);
    rchk(7'h32, 16'd3);
    rchk(7'h34, 16'hff38);
    rchk(7'h34, 16'h0064);
    rchk(7'h34, 16'hfe00);
    rchk(7'h32, 16'd0);
    rchk(7'h34, 16'h7fff);
  endtask

  task automatic t_cycles();
    new_pack <= 1'b1;
    @(posedge clk);
    new_pack <= 1'b0;
    tick(1);
    eng.mean_current <= 16'hf8f8;
    tick(2);
    eng.mean_current <= 16'h0000;
    rchk(7'h2a, 16'd1);
    rchk(7'h1e, 16'hf8f8);
    profile_sel <= 1'b1;
    rchk(7'h2a, 16'd0);
    profile_sel <= 1'b0;
    new_pack <= 1'b1;
    @(posedge clk);
    new_pack <= 1'b0;
    rchk(7'h2a, 16'd0);
  endtask

  task automatic t_idle();
    tick(1);
    eng.mean_current <= 16'd150;
    tick(2);
    rchk(7'h1a, 16'd100);
    tick(1);
    eng.mean_current <= 16'h0000;
    rchk(7'h1a, 16'h0067);
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    eng = '0;
    eng_valid = 1'b1;
    cfg = '{initial_idle: 16'd100, deadband: 16'd5, initial_peak: 16'hfc18,
            cycle_discharge_threshold: 16'd1, config_mirror: 16'h5a3c};
    profile_sel = 1'b0;
    new_pack = 1'b0;
    log_on = 1'b0;
    log_off = 1'b0;
    go = 1'b0;
    cmd = 7'h00;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset_vals();
    t_words();
    t_flags();
    t_log();
    t_cycles();
    t_idle();
    stop_test();
  end
endmodule
